/* File: rtl/avsc_consts.svh */
// Offsets, field positions, reset values and timing for the aux line and system control block
`ifndef AVSC_CONSTS_SVH
`define AVSC_CONSTS_SVH

// ****************************************
// Register byte offsets (7-bit address)
// ****************************************
`define AVSC_OFS_WCOUNT 7'h00
`define AVSC_OFS_LINEFN 7'h36
`define AVSC_OFS_DIRLVL 7'h38
`define AVSC_OFS_STATUS 7'h3C
`define AVSC_OFS_GCMD 7'h3E
`define AVSC_OFS_LOTLO 7'h52
`define AVSC_OFS_LOTHI 7'h54
`define AVSC_OFS_PART 7'h56
`define AVSC_OFS_SERIAL 7'h58
`define AVSC_OFS_OWNER 7'h5C

// ****************************************
// Special words
// ****************************************
`define AVSC_ESCAPE_WORD 16'hE8E8

// ****************************************
// Global command bits
// ****************************************
`define AVSC_GC_PWRDN 1
`define AVSC_GC_SELFTEST 2
`define AVSC_GC_CLRSTAT 4
`define AVSC_GC_FLASHTEST 5

// ****************************************
// Status bits
// ****************************************
`define AVSC_ST_ESC 4
`define AVSC_ST_SELFTEST 5
`define AVSC_ST_FLASH 6
`define AVSC_ST_READY 7

// ****************************************
// Reset values
// ****************************************
`define AVSC_RST_LINEFN 6'h0F
`define AVSC_RST_DIRLVL 2'h0
`define AVSC_RST_OWNER 16'h0000
`define AVSC_RST_STATUS 16'h0000

// ****************************************
// Timing
// ****************************************
`define AVSC_CLK_PERIOD_PS 25000
`define AVSC_TRIG_MIN_PS 2600000
`define AVSC_TRIG_MIN_CYC ((`AVSC_TRIG_MIN_PS + `AVSC_CLK_PERIOD_PS - 1) / `AVSC_CLK_PERIOD_PS)

`endif

/* File: rtl/avsc_pkg.sv */
// Types for the aux line and system control block
package avsc_pkg;

   typedef enum logic [1:0] {
      AVSC_FN_GPIO = 2'h0,
      AVSC_FN_ALARM = 2'h1,
      AVSC_FN_TRIG = 2'h2,
      AVSC_FN_BUSY = 2'h3
   } avsc_fn_t;

   typedef struct packed {
      avsc_fn_t fn;
      logic pol;
   } avsc_line_cfg_t;

   typedef enum logic [1:0] {
      AVSC_PWR_AWAKE = 2'b01,
      AVSC_PWR_ASLEEP = 2'b10
   } avsc_pwr_t;

   typedef struct packed {
      logic wr;
      logic [6:0] addr;
      logic [7:0] data;
   } avsc_frame_t;

endpackage : avsc_pkg

/* File: rtl/avsc_top.sv */
// Aux line and system control: serial register port, aux lines, power state, status and commands
// Notes on behaviour
// - Power-down command bit puts device asleep
// - Auto-sleep bit sleeps after record completes
// - Chip select falling edge wakes to idle
// - Trigger-mode first line toggle also wakes
// - Without auto-sleep, stay awake after record
// - Busy: accept only status read, escape
// - Status bit 7: zero busy, one ready
// - Escape aborts capture and sets status bit 4, nothing else
// - Busy line active during recording and commands
// - Reset line function: first line busy high
// - Trigger starts on falling edge, minimum high
// - Alarm line active on any axis alarm
// - Split bit: second Alarm 2, first Alarm 1
// - Clear-status clears flags, alarm lines inactive
// - Two-bit field selects line function
// - Polarity bits: one high, zero low
// - Direction register sets direction, level, reports input
// - Self-test command reports result in bit 5
// - Flash-test command reports checksum in bit 6
// - Counter increments on each flash write
// - Owner tag writable; identity codes read only
// - Command bits self-clear when function completes
// - Error flags sticky until clear or record start
`timescale 1ns/10ps
`include "avsc_consts.svh"

module avsc_top
   import avsc_pkg::*;
#(
   parameter logic [15:0] P_LOT_LOW = 16'h1111,  // Arbitrary value
   parameter logic [15:0] P_LOT_HIGH = 16'h2222, // Arbitrary value
   parameter logic [15:0] P_PART = 16'h1234,     // Arbitrary value
   parameter logic [15:0] P_SERIAL = 16'h0001    // Arbitrary value
) (
   // System clock and reset
   input wire logic I_SYS_CLK,
   input wire logic I_RSTN,
   // Serial port
   input wire logic I_SPI_SCLK,
   input wire logic I_SPI_CS_N,
   input wire logic I_SPI_DIN,
   output logic O_SPI_DOUT,
   // Aux lines
   input wire logic I_AUX_A,
   output logic O_AUX_A,
   output logic O_AUX_A_OE,
   input wire logic I_AUX_B,
   output logic O_AUX_B,
   output logic O_AUX_B_OE,
   // Internal processor status
   input wire logic I_CAPTURE_ACTIVE,
   input wire logic I_PROC_BUSY,
   input wire logic I_RECORD_START,
   input wire logic I_RECORD_DONE,
   input wire logic I_AUTO_SLEEP,
   input wire logic I_ALARM_SPLIT,
   input wire logic [6:0] I_ALARM_SET,
   input wire logic [3:0] I_ERR_SET,
   input wire logic [15:0] I_CMD_DONE,
   input wire logic I_TEST_FAIL,
   input wire logic I_FLASH_WRITE,
   // Requests to internal processor
   output logic [15:0] O_CMD_REQ,
   output logic O_CAPTURE_ABORT,
   output logic O_TRIGGER,
   output logic O_SLEEP
);

   // ****************************************
   // Reset release
   // ****************************************
   logic [1:0] rst_sync_reg;
   logic rst_n;

   always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         rst_sync_reg <= 2'h0;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_reg[1];

   // ****************************************
   // Serial link domain
   // ****************************************
   logic [3:0] bit_cnt_reg;
   logic [14:0] rx_shift_reg;
   logic [15:0] rx_word_reg;
   logic rx_tgl_reg;
   logic [14:0] tx_shift_reg;
   logic [15:0] tx_word_reg;

   // Bit counter cleared while chip select is high
   always_ff @(posedge I_SPI_SCLK or posedge I_SPI_CS_N) begin
      if (I_SPI_CS_N) begin
         bit_cnt_reg <= 4'h0;
         rx_shift_reg <= 15'h0000;
      end else begin
         bit_cnt_reg <= bit_cnt_reg + 4'h1;
         rx_shift_reg <= {rx_shift_reg[13:0], I_SPI_DIN};
      end
   end

   // Completed word held until the next frame ends
   always_ff @(posedge I_SPI_SCLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         rx_word_reg <= 16'h0000;
         rx_tgl_reg <= 1'b0;
      end else if (!I_SPI_CS_N && bit_cnt_reg == 4'hF) begin
         rx_word_reg <= {rx_shift_reg, I_SPI_DIN};
         rx_tgl_reg <= ~rx_tgl_reg;
      end
   end

   // Answer word is static between frames, loaded at first falling edge
   always_ff @(negedge I_SPI_SCLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         O_SPI_DOUT <= 1'b0;
         tx_shift_reg <= 15'h0000;
      end else if (bit_cnt_reg == 4'h0) begin
         O_SPI_DOUT <= tx_word_reg[15];
         tx_shift_reg <= tx_word_reg[14:0];
      end else begin
         O_SPI_DOUT <= tx_shift_reg[14];
         tx_shift_reg <= {tx_shift_reg[13:0], 1'b0};
      end
   end

   // ****************************************
   // Input synchronisers: cs, aux a, aux b, frame toggle
   // ****************************************
   logic [3:0] sync1_reg;
   logic [3:0] sync2_reg;
   logic [3:0] sync3_reg;
   logic [3:0] filt_reg;
   logic [3:0] filt_prev_reg;
   logic [3:0] filt_chg;

   always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         sync1_reg <= 4'h1;
         sync2_reg <= 4'h1;
         sync3_reg <= 4'h1;
         filt_reg <= 4'h1;
         filt_prev_reg <= 4'h1;
      end else begin
         sync1_reg <= {rx_tgl_reg, I_AUX_B, I_AUX_A, I_SPI_CS_N};
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         filt_prev_reg <= filt_reg;
         for (int i = 0; i < 4; i++) begin
            if (sync2_reg[i] == sync3_reg[i]) begin
               filt_reg[i] <= sync3_reg[i];
            end
         end
      end
   end
   assign filt_chg = filt_reg ^ filt_prev_reg;

   // ****************************************
   // Registers and decode
   // ****************************************
   avsc_line_cfg_t cfg_a;
   avsc_line_cfg_t cfg_b;
   avsc_frame_t frm;
   logic [5:0] linefn_reg;
   logic [1:0] dir_reg;
   logic [1:0] lvl_reg;
   logic [15:0] owner_reg;
   logic [15:0] wcount_reg;
   logic [15:0] cmd_reg;
   logic [15:0] status_reg;
   logic busy;
   logic rx_evt;
   logic is_esc;
   logic is_stat_rd;
   logic accept;
   logic wr_en;
   logic [1:0] pin_in;

   assign frm = rx_word_reg;
   assign rx_evt = filt_chg[3];
   assign is_esc = rx_word_reg == `AVSC_ESCAPE_WORD;
   assign is_stat_rd = !frm.wr && frm.addr == `AVSC_OFS_STATUS;
   assign busy = (|cmd_reg) | I_CAPTURE_ACTIVE | I_PROC_BUSY;
   assign accept = rx_evt && (!busy || is_esc || is_stat_rd);
   assign wr_en = accept && frm.wr && !is_esc;
   assign cfg_a = {linefn_reg[3:2], linefn_reg[0]};
   assign cfg_b = {linefn_reg[5:4], linefn_reg[1]};
   assign pin_in = filt_reg[2:1];

   function automatic logic hit(input logic [6:0] a, input logic [6:0] ofs);
      hit = a[6:1] == ofs[6:1];
   endfunction : hit

   function automatic logic [15:0] rd_mux(input logic [6:0] a);
      logic [1:0] lvl_rd;
      lvl_rd = (dir_reg & lvl_reg) | (~dir_reg & pin_in);
      if (hit(a, `AVSC_OFS_WCOUNT)) begin
         rd_mux = wcount_reg;
      end else if (hit(a, `AVSC_OFS_LINEFN)) begin
         rd_mux = {10'h000, linefn_reg};
      end else if (hit(a, `AVSC_OFS_DIRLVL)) begin
         rd_mux = {6'h00, lvl_rd, 6'h00, dir_reg};
      end else if (hit(a, `AVSC_OFS_STATUS)) begin
         rd_mux = {1'b0, status_reg[14:8], ~busy, status_reg[6:0]};
      end else if (hit(a, `AVSC_OFS_LOTLO)) begin
         rd_mux = P_LOT_LOW;
      end else if (hit(a, `AVSC_OFS_LOTHI)) begin
         rd_mux = P_LOT_HIGH;
      end else if (hit(a, `AVSC_OFS_PART)) begin
         rd_mux = P_PART;
      end else if (hit(a, `AVSC_OFS_SERIAL)) begin
         rd_mux = P_SERIAL;
      end else if (hit(a, `AVSC_OFS_OWNER)) begin
         rd_mux = owner_reg;
      end else begin
         rd_mux = 16'h0000;
      end
   endfunction : rd_mux

   // Read answer prepared for the next frame
   always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         tx_word_reg <= 16'h0000;
      end else if (accept && !frm.wr) begin
         tx_word_reg <= rd_mux(frm.addr);
      end
   end

   // Line function register, byte writes only reach its low byte
   always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         linefn_reg <= `AVSC_RST_LINEFN;
      end else if (wr_en && frm.addr == `AVSC_OFS_LINEFN) begin
         linefn_reg <= frm.data[5:0];
      end
   end

   // Direction and level register
   always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         dir_reg <= `AVSC_RST_DIRLVL;
         lvl_reg <= `AVSC_RST_DIRLVL;
      end else if (wr_en && frm.addr == `AVSC_OFS_DIRLVL) begin
         dir_reg <= frm.data[1:0];
      end else if (wr_en && frm.addr == (`AVSC_OFS_DIRLVL | 7'h01)) begin
         lvl_reg <= frm.data[1:0];
      end
   end

   // Owner tag; identity and counter offsets have no write path
   always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         owner_reg <= `AVSC_RST_OWNER;
      end else if (wr_en && frm.addr == `AVSC_OFS_OWNER) begin
         owner_reg[7:0] <= frm.data;
      end else if (wr_en && frm.addr == (`AVSC_OFS_OWNER | 7'h01)) begin
         owner_reg[15:8] <= frm.data;
      end
   end

   // Flash write cycle counter
   always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         wcount_reg <= 16'h0000;
      end else if (I_FLASH_WRITE) begin
         wcount_reg <= wcount_reg + 16'h0001;
      end
   end

   // ****************************************
   // Global commands
   // ****************************************
   logic [15:0] cmd_set;
   logic [15:0] cmd_internal;

   always_comb begin
      cmd_set = 16'h0000;
      if (wr_en && frm.addr == `AVSC_OFS_GCMD) begin
         cmd_set[7:0] = frm.data;
      end else if (wr_en && frm.addr == (`AVSC_OFS_GCMD | 7'h01)) begin
         cmd_set[15:8] = frm.data;
      end
   end

   // Power-down and clear-status finish here in one cycle
   always_comb begin
      cmd_internal = 16'h0000;
      cmd_internal[`AVSC_GC_PWRDN] = 1'b1;
      cmd_internal[`AVSC_GC_CLRSTAT] = 1'b1;
   end

   always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         cmd_reg <= 16'h0000;
      end else begin
         cmd_reg <= (cmd_reg & ~(I_CMD_DONE | cmd_internal)) | cmd_set;
      end
   end
   assign O_CMD_REQ = cmd_reg;

   // ****************************************
   // Status flags
   // ****************************************
   logic [15:0] stat_set;
   logic stat_clr;

   always_comb begin
      stat_set = 16'h0000;
      stat_set[14:8] = I_ALARM_SET;
      stat_set[3:0] = I_ERR_SET;
      stat_set[`AVSC_ST_ESC] = rx_evt && is_esc && I_CAPTURE_ACTIVE;
      stat_set[`AVSC_ST_SELFTEST] = I_CMD_DONE[`AVSC_GC_SELFTEST] && cmd_reg[`AVSC_GC_SELFTEST] && I_TEST_FAIL;
      stat_set[`AVSC_ST_FLASH] = I_CMD_DONE[`AVSC_GC_FLASHTEST] && cmd_reg[`AVSC_GC_FLASHTEST] && I_TEST_FAIL;
   end
   assign stat_clr = cmd_reg[`AVSC_GC_CLRSTAT] || I_RECORD_START;

   // New events win over a clear in the same cycle
   always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         status_reg <= `AVSC_RST_STATUS;
      end else begin
         status_reg <= (stat_clr ? 16'h0000 : status_reg) | stat_set;
      end
   end

   // Escape aborts only an ongoing capture
   always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         O_CAPTURE_ABORT <= 1'b0;
      end else begin
         O_CAPTURE_ABORT <= rx_evt && is_esc && I_CAPTURE_ACTIVE;
      end
   end

   // ****************************************
   // Trigger inputs
   // ****************************************
   logic [1:0] trig_act;
   logic [1:0] trig_prev_reg;
   logic [7:0] trig_cnt_reg [2];
   logic [1:0] trig_fire;
   localparam logic [7:0] TRIG_MIN = 8'(`AVSC_TRIG_MIN_CYC);

   assign trig_act[0] = (cfg_a.fn == AVSC_FN_TRIG) && (pin_in[0] == cfg_a.pol);
   assign trig_act[1] = (cfg_b.fn == AVSC_FN_TRIG) && (pin_in[1] == cfg_b.pol);

   always_comb begin
      for (int i = 0; i < 2; i++) begin
         trig_fire[i] = trig_prev_reg[i] && !trig_act[i] && trig_cnt_reg[i] >= TRIG_MIN;
      end
   end

   always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         trig_prev_reg <= 2'h0;
         trig_cnt_reg[0] <= 8'h00;
         trig_cnt_reg[1] <= 8'h00;
         O_TRIGGER <= 1'b0;
      end else begin
         trig_prev_reg <= trig_act;
         O_TRIGGER <= |trig_fire;
         for (int i = 0; i < 2; i++) begin
            if (!trig_act[i]) begin
               trig_cnt_reg[i] <= 8'h00;
            end else if (trig_cnt_reg[i] < TRIG_MIN) begin
               trig_cnt_reg[i] <= trig_cnt_reg[i] + 8'h01;
            end
         end
      end
   end

   // ****************************************
   // Power state
   // ****************************************
   avsc_pwr_t pwr_reg;
   logic wake;
   logic go_sleep;

   assign wake = (filt_chg[0] && !filt_reg[0])
      || (filt_chg[1] && cfg_a.fn == AVSC_FN_TRIG);
   assign go_sleep = cmd_reg[`AVSC_GC_PWRDN]
      || (I_RECORD_DONE && I_AUTO_SLEEP);

   always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         pwr_reg <= AVSC_PWR_AWAKE;
      end else begin
         case (pwr_reg)
            AVSC_PWR_AWAKE: begin
               if (go_sleep) begin
                  pwr_reg <= AVSC_PWR_ASLEEP;
               end
            end
            AVSC_PWR_ASLEEP: begin
               if (wake) begin
                  pwr_reg <= AVSC_PWR_AWAKE;
               end
            end
            default: begin
               pwr_reg <= AVSC_PWR_AWAKE;
            end
         endcase
      end
   end

   always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         O_SLEEP <= 1'b0;
      end else begin
         O_SLEEP <= (pwr_reg == AVSC_PWR_ASLEEP) ? !wake : go_sleep;
      end
   end

   // ****************************************
   // Aux line drivers
   // ****************************************
   logic [1:0] alarm_act;
   logic any_alarm;
   logic [1:0] line_out;
   logic [1:0] line_oe;

   assign any_alarm = |status_reg[13:8];
   assign alarm_act[0] = I_ALARM_SPLIT ? |status_reg[10:8] : any_alarm;
   assign alarm_act[1] = I_ALARM_SPLIT ? |status_reg[13:11] : any_alarm;

   function automatic logic [1:0] drive(input avsc_line_cfg_t c, input logic alm, input logic d, input logic l);
      case (c.fn)
         AVSC_FN_GPIO: drive = {d, l};
         AVSC_FN_ALARM: drive = {1'b1, alm == c.pol};
         AVSC_FN_TRIG: drive = 2'h0;
         default: drive = {1'b1, busy == c.pol};
      endcase
   endfunction : drive

   assign {line_oe[0], line_out[0]} = drive(cfg_a, alarm_act[0], dir_reg[0], lvl_reg[0]);
   assign {line_oe[1], line_out[1]} = drive(cfg_b, alarm_act[1], dir_reg[1], lvl_reg[1]);

   always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         O_AUX_A <= 1'b0;
         O_AUX_A_OE <= 1'b0;
         O_AUX_B <= 1'b0;
         O_AUX_B_OE <= 1'b0;
      end else begin
         O_AUX_A <= line_out[0];
         O_AUX_A_OE <= line_oe[0];
         O_AUX_B <= line_out[1];
         O_AUX_B_OE <= line_oe[1];
      end
   end

endmodule : avsc_top

/* File: bench/avsc_top_props.sv */
// Concurrent checks on the ports of the aux line and system control block
`timescale 1ns/10ps
module avsc_top_props (
   // Clock and reset
   input wire logic I_SYS_CLK,
   input wire logic I_RSTN,
   // Watched inputs
   input wire logic I_SPI_CS_N,
   input wire logic I_AUX_A,
   input wire logic I_CAPTURE_ACTIVE,
   input wire logic I_RECORD_DONE,
   input wire logic I_AUTO_SLEEP,
   input wire logic [15:0] I_CMD_DONE,
   // Watched outputs
   input wire logic O_AUX_A_OE,
   input wire logic O_AUX_B_OE,
   input wire logic [15:0] O_CMD_REQ,
   input wire logic O_CAPTURE_ABORT,
   input wire logic O_TRIGGER,
   input wire logic O_SLEEP
);
   logic [3:0] cs_age;
   logic [3:0] act_age;
   logic aux_d;
   default clocking cb @(posedge I_SYS_CLK);
   endclocking
   default disable iff (!I_RSTN);
   // ****************
   // Cycles since serial or wake activity
   // ****************
   always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         cs_age <= 4'hF;
         act_age <= 4'hF;
         aux_d <= 1'b0;
      end else begin
         aux_d <= I_AUX_A;
         cs_age <= !I_SPI_CS_N ? 4'h0 : (cs_age == 4'hF ? cs_age : cs_age + 4'h1);
         act_age <= (!I_SPI_CS_N || I_AUX_A != aux_d) ? 4'h0 : (act_age == 4'hF ? act_age : act_age + 4'h1);
      end
   end
   chk_abort_cause: assert property (O_CAPTURE_ABORT |-> $past(I_CAPTURE_ACTIVE) && cs_age < 4'hC)
      else $error("abort without capture or escape frame");
   chk_abort_pulse: assert property (O_CAPTURE_ABORT |=> !O_CAPTURE_ABORT)
      else $error("abort longer than one cycle");
   chk_trig_pulse: assert property (O_TRIGGER |=> !O_TRIGGER)
      else $error("trigger longer than one cycle");
   chk_trig_undriven: assert property (O_TRIGGER |-> !O_AUX_A_OE || !O_AUX_B_OE)
      else $error("trigger while both lines driven");
   chk_req_hold: assert property (O_CMD_REQ[2] && !I_CMD_DONE[2] |=> O_CMD_REQ[2])
      else $error("command bit cleared before done");
   chk_req_done: assert property (O_CMD_REQ[5] && I_CMD_DONE[5] |=> !O_CMD_REQ[5])
      else $error("command bit kept after done");
   chk_req_from_spi: assert property ($rose(O_CMD_REQ[2]) |-> cs_age < 4'hC)
      else $error("command raised without a frame");
   chk_wake_cause: assert property ($fell(O_SLEEP) |-> act_age < 4'hC)
      else $error("woke without select or line change");
   chk_auto_sleep: assert property (I_RECORD_DONE && I_AUTO_SLEEP |-> ##[1:6] O_SLEEP)
      else $error("no sleep after record with auto sleep");
   chk_stay_awake: assert property (I_RECORD_DONE && !I_AUTO_SLEEP && !O_SLEEP && I_SPI_CS_N |=> !O_SLEEP [*3])
      else $error("slept after record without auto sleep");
   cov_trigger: cover property (O_TRIGGER);
   cov_abort: cover property (O_CAPTURE_ABORT);
   cov_wake: cover property ($fell(O_SLEEP));
endmodule : avsc_top_props

/* File: bench/avsc_host_model.sv */
// Host serial master model for the register port
`timescale 1ns/10ps
module avsc_host_model (
   // Serial lines
   output logic o_sclk,
   output logic o_cs_n,
   output logic o_din,
   input wire logic i_dout
);
   initial begin
      o_sclk = 1'b1;
      o_cs_n = 1'b0;
      o_din = 1'b0;
      #1 o_cs_n = 1'b1; // Rising select clears the bit counter
   end
   // One 16-clock frame, then the inter-frame gap
   task xfer(input logic [15:0] w, output logic [15:0] r);
      o_cs_n = 1'b0;
      #4;
      for (int i = 15; i >= 0; i--) begin
         o_sclk = 1'b0;
         o_din = w[i];
         #3;
         o_sclk = 1'b1;
         r[i] = i_dout;
         #3;
      end
      #2;
      o_cs_n = 1'b1;
      o_din = ~o_din;
      #400;
   endtask : xfer
   // Repeat escape and poll ready
   task abort_capture(output logic [15:0] st);
      logic [15:0] junk;
      xfer(16'h3C00, junk);
      xfer(16'h3C00, st);
      for (int n = 0; n < 4 && !st[7]; n++) begin
         xfer(16'hE8E8, junk);
         #50000;
         xfer(16'h3C00, junk);
         xfer(16'h3C00, st);
      end
   endtask : abort_capture
endmodule : avsc_host_model

/* File: bench/tb_aux_line_and_system_control.sv */
// Self-checking bench for the aux line and system control block
`timescale 1ns/10ps
`include "avsc_consts.svh"
module tb_aux_line_and_system_control;
   logic clk, rstn, sclk, cs_n, din, dout, ext_a, ext_b, aux_a, aux_b, oa, ob, oea, oeb;
   logic cap, busy, rstart, rdone, autos, split, tfail, fwr, abort, trig, sleep, lv;
   logic [6:0] alarm;
   logic [3:0] err;
   logic [15:0] done, req, rv, rr, c0, obs, e;
   int errors, cmp_count, trig_n, abort_n;
   logic [15:0] q[$];
   event obs_ev;
   assign aux_a = oea ? oa : ext_a;
   assign aux_b = oeb ? ob : ext_b;
   avsc_top #(.P_PART(16'h5A0F)) dut_u ( // Arbitrary value
      .I_SYS_CLK(clk), .I_RSTN(rstn), .I_SPI_SCLK(sclk), .I_SPI_CS_N(cs_n), .I_SPI_DIN(din),
      .O_SPI_DOUT(dout), .I_AUX_A(aux_a), .O_AUX_A(oa), .O_AUX_A_OE(oea), .I_AUX_B(aux_b),
      .O_AUX_B(ob), .O_AUX_B_OE(oeb), .I_CAPTURE_ACTIVE(cap), .I_PROC_BUSY(busy),
      .I_RECORD_START(rstart), .I_RECORD_DONE(rdone), .I_AUTO_SLEEP(autos), .I_ALARM_SPLIT(split),
      .I_ALARM_SET(alarm), .I_ERR_SET(err), .I_CMD_DONE(done), .I_TEST_FAIL(tfail),
      .I_FLASH_WRITE(fwr), .O_CMD_REQ(req), .O_CAPTURE_ABORT(abort), .O_TRIGGER(trig), .O_SLEEP(sleep));
   avsc_host_model host_u (.o_sclk(sclk), .o_cs_n(cs_n), .o_din(din), .i_dout(dout));
   // ****************
   // Helpers
   // ****************
   task report_and_stop;
      if (errors == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : report_and_stop
   task note(input logic [15:0] x, input logic [15:0] a);
      q.push_back(x);
      obs = a;
      ->obs_ev;
      @(negedge clk);
   endtask : note
   task wt(input int n);
      repeat (n) @(negedge clk);
   endtask : wt
   task wr(input logic [6:0] a, input logic [7:0] d);
      host_u.xfer({1'b1, a, d}, rv);
      @(negedge clk);
   endtask : wr
   task wr16(input logic [6:0] a, input logic [15:0] d);
      wr(a, d[7:0]);
      wr(a + 7'h1, d[15:8]);
   endtask : wr16
   task rd(input logic [6:0] a, output logic [15:0] r);
      host_u.xfer({1'b0, a, 8'h00}, rv);
      host_u.xfer(16'h3C00, r);
   endtask : rd
   task chk_rd(input logic [6:0] a, input logic [15:0] x);
      rd(a, c0);
      note(x, c0);
   endtask : chk_rd
   task wait_sleep(input logic v);
      for (int i = 0; i < 60 && sleep !== v; i++) @(negedge clk);
      if (sleep !== v) errors++;
      note({15'h0000, v}, {15'h0000, sleep});
   endtask : wait_sleep
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial forever begin
      @(obs_ev);
      e = q.pop_front();
      cmp_count++;
      if (e !== obs) begin
         errors++;
         $display("wrong value at %0t: expected %h got %h", $time, e, obs);
      end
   end
   always @(posedge clk) begin
      if (trig === 1'b1) trig_n++;
      if (abort === 1'b1) begin
         abort_n++;
         cap <= 1'b0;
      end
   end
   initial begin
      repeat (60000) @(posedge clk);
      errors++;
      report_and_stop;
   end
   // ****************
   // Main sequence
   // ****************
   initial begin
      {rstn, ext_a, ext_b, cap, busy, rstart, rdone, autos, split, tfail, fwr} = 11'h000;
      {alarm, err, done} = 27'h0;
      {errors, cmp_count, trig_n, abort_n} = {4{32'h0}};
      rr = 16'($urandom(53415));
      wt(6);
      rstn = 1'b1;
      wt(8);
      note(16'h0001, {14'h0, oa, oea});
      chk_rd(`AVSC_OFS_LINEFN, 16'h000F);
      chk_rd(`AVSC_OFS_DIRLVL, 16'h0000);
      chk_rd(`AVSC_OFS_OWNER, 16'h0000);
      @(negedge clk) busy = 1'b1;
      wt(8);
      note(16'h0003, {14'h0, oa, oea});
      wr16(`AVSC_OFS_OWNER, 16'hA5C3);
      chk_rd(`AVSC_OFS_STATUS, 16'h0000);
      @(negedge clk) busy = 1'b0;
      wt(8);
      chk_rd(`AVSC_OFS_OWNER, 16'h0000);
      chk_rd(`AVSC_OFS_STATUS, 16'h0080);
      rr = 16'($urandom);
      wr16(`AVSC_OFS_OWNER, rr);
      chk_rd(`AVSC_OFS_OWNER, rr);
      wr16(`AVSC_OFS_PART, ~rr);
      chk_rd(`AVSC_OFS_PART, 16'h5A0F);
      wr16(7'h40, rr);
      chk_rd(7'h40, 16'h0000);
      wr16(`AVSC_OFS_WCOUNT, ~rr);
      repeat (3) begin
         @(negedge clk) fwr = 1'b1;
         @(negedge clk) fwr = 1'b0;
      end
      chk_rd(`AVSC_OFS_WCOUNT, 16'h0003);
      wr(`AVSC_OFS_GCMD, 8'h04);
      note(16'h0004, req);
      note(16'h0003, {14'h0, oa, oea});
      tfail = 1'b1;
      done = 16'h0004;
      @(negedge clk) done = 16'h0000;
      wt(2);
      note(16'h0000, req);
      wr(`AVSC_OFS_GCMD, 8'h20);
      @(negedge clk) done = 16'h0020;
      @(negedge clk) done = 16'h0000;
      chk_rd(`AVSC_OFS_STATUS, 16'h00E0);
      @(negedge clk) err = 4'h1;
      @(negedge clk) err = 4'h0;
      chk_rd(`AVSC_OFS_STATUS, 16'h00E1);
      @(negedge clk) rstart = 1'b1;
      @(negedge clk) rstart = 1'b0;
      chk_rd(`AVSC_OFS_STATUS, 16'h0080);
      @(negedge clk) err = 4'h4;
      @(negedge clk) err = 4'h0;
      wr(`AVSC_OFS_GCMD, 8'h10);
      chk_rd(`AVSC_OFS_STATUS, 16'h0080);
      @(negedge clk) busy = 1'b1;
      host_u.xfer(`AVSC_ESCAPE_WORD, rv);
      note(16'h0000, 16'(abort_n));
      @(negedge clk) busy = 1'b0;
      cap = 1'b1;
      host_u.abort_capture(rr);
      note(16'h0001, 16'(abort_n));
      note(16'h0090, rr);
      wr(`AVSC_OFS_GCMD, 8'h10);
      wr(`AVSC_OFS_LINEFN, 8'h17);
      @(negedge clk) split = 1'b1;
      alarm = 7'h08;
      @(negedge clk) alarm = 7'h00;
      wt(8);
      note(16'h0001, {14'h0, oa, ob});
      split = 1'b0;
      wt(4);
      note(16'h0003, {14'h0, oa, ob});
      wr(`AVSC_OFS_LINEFN, 8'h14);
      note(16'h0000, {14'h0, oa, ob});
      wr(`AVSC_OFS_GCMD, 8'h10);
      note(16'h0003, {14'h0, oa, ob});
      wr(`AVSC_OFS_LINEFN, 8'h00);
      lv = 1'($urandom);
      wr16(`AVSC_OFS_DIRLVL, {7'h00, lv, 7'h00, 1'b1});
      @(negedge clk) ext_b = 1'b1;
      wt(8);
      note({13'h0, lv, 2'b10}, {13'h0, oa, oea, oeb});
      chk_rd(`AVSC_OFS_DIRLVL, {6'h00, 1'b1, lv, 8'h01});
      @(negedge clk) ext_b = 1'b0;
      wt(8);
      chk_rd(`AVSC_OFS_DIRLVL, {6'h00, 1'b0, lv, 8'h01});
      wr(`AVSC_OFS_LINEFN, 8'h0B);
      ext_a = 1'b1;
      wt(60);
      ext_a = 1'b0;
      wt(20);
      note(16'h0000, {trig_n[14:0], oea});
      ext_a = 1'b1;
      wt(110);
      ext_a = 1'b0;
      wt(20);
      note(16'h0002, {trig_n[14:0], oea});
      wr(`AVSC_OFS_GCMD, 8'h02);
      wait_sleep(1'b1);
      ext_a = 1'b1;
      wait_sleep(1'b0);
      ext_a = 1'b0;
      wr(`AVSC_OFS_GCMD, 8'h02);
      wait_sleep(1'b1);
      host_u.xfer(16'h3C00, rv);
      wait_sleep(1'b0);
      @(negedge clk) rdone = 1'b1;
      @(negedge clk) rdone = 1'b0;
      wt(6);
      note(16'h0000, {15'h0000, sleep});
      autos = 1'b1;
      rdone = 1'b1;
      @(negedge clk) rdone = 1'b0;
      wait_sleep(1'b1);
      report_and_stop;
   end
endmodule : tb_aux_line_and_system_control
bind avsc_top avsc_top_props props_u (
   .I_SYS_CLK(I_SYS_CLK), .I_RSTN(I_RSTN), .I_SPI_CS_N(I_SPI_CS_N), .I_AUX_A(I_AUX_A),
   .I_CAPTURE_ACTIVE(I_CAPTURE_ACTIVE), .I_RECORD_DONE(I_RECORD_DONE), .I_AUTO_SLEEP(I_AUTO_SLEEP),
   .I_CMD_DONE(I_CMD_DONE), .O_AUX_A_OE(O_AUX_A_OE), .O_AUX_B_OE(O_AUX_B_OE), .O_CMD_REQ(O_CMD_REQ),
   .O_CAPTURE_ABORT(O_CAPTURE_ABORT), .O_TRIGGER(O_TRIGGER), .O_SLEEP(O_SLEEP));
